// [rtl/ees_pkg.sv]
package ees_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 2048;
  localparam int HI_W = 3;

  // fixed device-type code in the upper nibble of the address byte
  localparam logic [3:0] DEV_TYPE = 4'ha;
  // bit positions inside the address byte
  localparam int RW_BIT = 0;
  localparam int HI_LSB = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_FREQ_HZ = 10_000_000;
  localparam longint WR_TIME_MS = 10;
  // longest time, so the division rounds down
  localparam int WR_CYCLES = int'((WR_TIME_MS * CLK_FREQ_HZ) / 1000);

  // ----------------------------------------------------------------
  // reset values and bit counter landmarks
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PTR_RST = 11'h000;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h1;

  // ----------------------------------------------------------------
  // link state machine, gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    L_IDLE   = 3'h0,
    L_DEV    = 3'h1,
    L_WADDR  = 3'h3,
    L_WDATA  = 3'h2,
    L_RSTART = 3'h6,
    L_READ   = 3'h7,
    L_IGNORE = 3'h5
  } ees_lstate_t;

endpackage

// [rtl/ees_eeprom_slave.sv]
`timescale 1ns/1ps
// Functional notes
// [RQ1] falling data with clock high opens frame
// [RQ2] rising data with clock high ends frame
// [RQ3] answer only when upper nibble matches type
// [RQ4] next three bits are address bits 10..8
// [RQ5] lowest address-byte bit: one read, zero write
// [RQ6] receiver pulls data low on ninth clock
// [RQ7] ack own address and every written byte
// [RQ8] read: eight bits, sample ack, continue or stop
// [RQ9] master: address, word address, data, stop
// [RQ10] stop after write starts busy programming cycle
// [RQ11] page write takes up to sixteen bytes
// [RQ12] write steps only the in-page offset
// [RQ13] offset wraps, later bytes replace earlier ones
// [RQ14] write-type address unacked while busy
// [RQ15] protect pin: ack addresses, refuse data
// [RQ16] counter holds last address plus one
// [RQ17] counter rolls from 2047 to zero
// [RQ18] master: dummy write then repeated start read
// [RQ19] sequential read steps the full counter
// [RQ20] reset pins block access and acknowledge
// [RQ21] programming ends within ten milliseconds
// [RQ22] protect pin low allows normal access
// [RQ23] eleven-bit address, low four bits offset
// [RQ24] aborted or dummy write only loads counter
module ees_eeprom_slave #(
  parameter int WR_CYCLES = ees_pkg::WR_CYCLES
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link, open-drain data split in three
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // protection and reset pins
  input wire logic wp_i,
  input wire logic ext_reset_i,
  input wire logic ext_reset_n_i,
  // status
  output logic busy_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(WR_CYCLES + 1);

  if (WR_CYCLES < 1) begin : g_chk
    $error("programming time must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    ees_pkg::ees_lstate_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [ees_pkg::ADDR_W-1:0] ptr;
    logic [ees_pkg::HI_W-1:0] hi;
    logic [ees_pkg::PAGE_BYTES-1:0] mask;
    logic drv;
    logic pending;
    logic due;
    logic start_seen;
    logic stop_seen;
    logic prog_seen;
    logic busy_s1;
    logic busy_s2;
    logic lock_s1;
    logic lock_s2;
    logic wp_s1;
    logic wp_s2;
    logic prog_s1;
    logic prog_s2;
  } ees_link_t;

  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] cnt;
    logic prog_tgl;
    logic stop_s1;
    logic stop_s2;
    logic stop_s3;
    logic pend_s1;
    logic pend_s2;
  } ees_core_t;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [ees_pkg::MEM_BYTES];
  logic [7:0] pbuf [ees_pkg::PAGE_BYTES];

  ees_link_t q;
  ees_link_t d;
  ees_core_t c_q;
  ees_core_t c_d;
  logic start_tgl;
  logic stop_tgl;
  logic oe_q;
  logic [7:0] byte_in;
  logic [7:0] mem_rd;
  logic busy_eff;
  logic buf_we;
  logic rd_load;
  logic prog_go;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // full counter step, rolls from the top location to zero
  function automatic logic [ees_pkg::ADDR_W-1:0] ees_inc(
    input logic [ees_pkg::ADDR_W-1:0] a
  );
    ees_inc = a + 11'h001;  // [RQ17]
  endfunction

  // ----------------------------------------------------------------
  // start and stop detectors, clocked by the data line
  // ----------------------------------------------------------------
  // toggles rather than pulses: the clock line is idle around them
  always_ff @(negedge sda_i or posedge rst_i) begin
    if (rst_i) begin
      start_tgl <= 1'b0;
    end else if (scl_i) begin
      start_tgl <= ~start_tgl;  // [RQ1]
    end
  end

  // stop reaches the core through its three-stage synchronizer and the link only at the next start: the link clock halts after it
  always_ff @(posedge sda_i or posedge rst_i) begin
    if (rst_i) begin
      stop_tgl <= 1'b0;
    end else if (scl_i) begin
      stop_tgl <= ~stop_tgl;  // [RQ2]
    end
  end

  // ----------------------------------------------------------------
  // link domain, clocked by the serial clock
  // ----------------------------------------------------------------
  assign byte_in = {q.sh[6:0], sda_i};
  // the array only changes while busy, when no read can be served
  assign mem_rd = mem[q.ptr];
  // local guard covers the gap before the core's busy arrives
  assign busy_eff = q.due | q.busy_s2;

  // next state of the link
  always_comb begin
    d = q;
    buf_we = 1'b0;
    rd_load = 1'b0;
    d.busy_s1 = c_q.busy;
    d.busy_s2 = q.busy_s1;
    d.lock_s1 = ext_reset_i | ~ext_reset_n_i;
    d.lock_s2 = q.lock_s1;
    d.wp_s1 = wp_i;
    d.wp_s2 = q.wp_s1;
    d.prog_s1 = c_q.prog_tgl;
    d.prog_s2 = q.prog_s1;
    d.start_seen = start_tgl;
    d.stop_seen = stop_tgl;
    // core has taken the page, its busy flag now guards the link
    if (q.prog_s2 != q.prog_seen) begin
      d.prog_seen = q.prog_s2;
      d.due = 1'b0;
    end
    if (start_tgl != q.start_seen) begin
      // a stop since the data bytes means programming is on its way
      if (q.pending && (stop_tgl != q.stop_seen)) begin
        d.due = 1'b1;  // [RQ10]
      end
      // repeated start or abort drops the page, keeps the counter
      d.pending = 1'b0;  // [RQ24]
      d.st = ees_pkg::L_DEV;
      d.cnt = ees_pkg::BIT_FIRST;
      d.sh = {7'h00, sda_i};
      d.drv = 1'b0;
    end else begin
      case (q.st)
        ees_pkg::L_DEV, ees_pkg::L_WADDR, ees_pkg::L_WDATA: begin
          if (q.cnt == ees_pkg::BIT_ACK) begin
            // ninth clock done, let go of the line
            d.cnt = 4'h0;
            d.drv = 1'b0;
          end else begin
            d.sh = byte_in;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == ees_pkg::BIT_LAST) begin
              if (q.st == ees_pkg::L_DEV) begin
                if ((byte_in[7:4] == ees_pkg::DEV_TYPE)  // [RQ3]
                    && !q.lock_s2                        // [RQ20]
                    && !busy_eff) begin                  // [RQ14]
                  d.drv = 1'b1;  // [RQ7]
                  if (byte_in[ees_pkg::RW_BIT]) begin
                    d.st = ees_pkg::L_RSTART;  // [RQ5]
                  end else begin
                    d.st = ees_pkg::L_WADDR;
                    d.hi = byte_in[ees_pkg::HI_LSB +: ees_pkg::HI_W];  // [RQ4]
                  end
                end else begin
                  d.st = ees_pkg::L_IGNORE;
                end
              end else if (q.st == ees_pkg::L_WADDR) begin
                d.ptr = {q.hi, byte_in};  // [RQ23]
                d.mask = '0;
                d.drv = 1'b1;  // [RQ6]
                d.st = ees_pkg::L_WDATA;
              end else if (q.wp_s2) begin
                // protected: no ack on data, nothing buffered
                d.st = ees_pkg::L_IGNORE;  // [RQ15]
              end else begin
                // page buffer entry, later bytes overwrite earlier
                buf_we = 1'b1;  // [RQ11] [RQ13] [RQ22]
                d.mask[q.ptr[ees_pkg::PAGE_W-1:0]] = 1'b1;
                d.ptr[ees_pkg::PAGE_W-1:0] = q.ptr[ees_pkg::PAGE_W-1:0] + 4'h1;  // [RQ12]
                d.pending = 1'b1;
                d.drv = 1'b1;  // [RQ7]
              end
            end
          end
        end
        ees_pkg::L_RSTART: begin
          // ack slot of a read address byte
          rd_load = 1'b1;
        end
        ees_pkg::L_READ: begin
          if (q.cnt == ees_pkg::BIT_ACK) begin
            if (!sda_i) begin
              rd_load = 1'b1;  // [RQ8]
            end else begin
              // no ack: stop sending and wait for the next frame
              d.st = ees_pkg::L_IGNORE;  // [RQ8]
              d.drv = 1'b0;
            end
          end else begin
            d.tx = {q.tx[6:0], 1'b1};
            d.cnt = q.cnt + 4'h1;
            // release after the eighth bit so the master can answer
            d.drv = (q.cnt == ees_pkg::BIT_LAST) ? 1'b0 : ~q.tx[6];
          end
        end
        ees_pkg::L_IDLE, ees_pkg::L_IGNORE: begin
          d.drv = 1'b0;
        end
        default: begin
          d.st = ees_pkg::L_IDLE;
          d.drv = 1'b0;
        end
      endcase
    end
    // next byte out, counter steps over the whole array
    if (rd_load) begin
      d.tx = mem_rd;
      d.ptr = ees_inc(q.ptr);  // [RQ16] [RQ19]
      d.drv = ~mem_rd[7];
      d.cnt = 4'h0;
      d.st = ees_pkg::L_READ;
    end
    // reset pins force the interface off until a fresh start
    if (q.lock_s2) begin
      d.st = ees_pkg::L_IDLE;  // [RQ20]
      d.drv = 1'b0;
    end
  end

  // link state register
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // page buffer, no reset needed: the mask says what is valid
  always_ff @(posedge scl_i) begin
    if (buf_we) begin
      pbuf[q.ptr[ees_pkg::PAGE_W-1:0]] <= byte_in;
    end
  end

  // data line changes only while the clock is low
  always_ff @(negedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= q.drv;  // [RQ6]
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;

  // ----------------------------------------------------------------
  // core domain, programming cycle on the system clock
  // ----------------------------------------------------------------
  // next state of the core
  always_comb begin
    c_d = c_q;
    prog_go = 1'b0;
    c_d.stop_s1 = stop_tgl;
    c_d.stop_s2 = c_q.stop_s1;
    c_d.stop_s3 = c_q.stop_s2;
    c_d.pend_s1 = q.pending;
    c_d.pend_s2 = c_q.pend_s1;
    if (c_q.busy) begin
      // whole count from the rise of busy, so the cycle never overruns
      if (c_q.cnt <= CNT_W'(1)) begin
        c_d.busy = 1'b0;  // [RQ21]
        c_d.cnt = '0;
      end else begin
        c_d.cnt = c_q.cnt - CNT_W'(1);
      end
    end else if ((c_q.stop_s3 != c_q.stop_s2) && c_q.pend_s2) begin
      c_d.busy = 1'b1;  // [RQ10]
      c_d.cnt = CNT_W'(WR_CYCLES);
      c_d.prog_tgl = ~c_q.prog_tgl;
      prog_go = 1'b1;
    end
  end

  // core state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // one-shot page commit; mask and page base stay still after stop
  always_ff @(posedge clk_i) begin
    if (prog_go) begin
      for (int i = 0; i < ees_pkg::PAGE_BYTES; i++) begin
        if (q.mask[i]) begin
          mem[{q.ptr[ees_pkg::ADDR_W-1:ees_pkg::PAGE_W], i[ees_pkg::PAGE_W-1:0]}]
            <= pbuf[i];  // [RQ11]
        end
      end
    end
  end

  assign busy_o = c_q.busy;

endmodule

// [sim/ees_eeprom_slave_monitor.sv]
`timescale 1ns/1ps
module ees_eeprom_slave_monitor #(
  parameter int WR_CYCLES = ees_pkg::WR_CYCLES
) (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic wp_i,
  input wire logic ext_reset_i,
  input wire logic ext_reset_n_i,
  input wire logic busy_o
);
  logic [31:0] bcnt_q;
  logic [3:0] hold_q;
  // rising serial clocks in a row with the line pulled low, saturating
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) hold_q <= '0;
    else if (!sda_oe_o) hold_q <= '0;
    else if (hold_q != 4'hf) hold_q <= hold_q + 4'h1;
  end
  // cycles spent programming, cleared when idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) bcnt_q <= '0;
    else bcnt_q <= busy_o ? bcnt_q + 32'h0000_0001 : '0;
  end
  odrain_a: assert property (@(posedge clk_i) disable iff (rst_i) sda_o == 1'b0)
    else $error("data line driven high");
  // an ack slot plus eight zero bits is the longest legal hold
  line_release_a: assert property (@(posedge scl_i) disable iff (rst_i)
    sda_oe_o |-> hold_q <= 4'h8) else $error("data line not released");
  busy_max_a: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o |-> bcnt_q <= WR_CYCLES) else $error("programming too long");
  busy_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(busy_o) |-> bcnt_q + 2 >= WR_CYCLES) else $error("programming cut short");
  busy_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_o) |-> scl_i && !sda_oe_o) else $error("busy outside idle bus");
  wp_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wp_i && $past(wp_i, 8) |-> !$rose(busy_o)) else $error("programmed while protected");
  busy_quiet_a: assert property (@(posedge scl_i) disable iff (rst_i)
    busy_o |-> !sda_oe_o) else $error("answered while busy");
  rst_hi_a: assert property (@(negedge scl_i) disable iff (rst_i)
    ext_reset_i && $past(ext_reset_i, 3) |=> !sda_oe_o) else $error("answered in reset");
  rst_lo_a: assert property (@(negedge scl_i) disable iff (rst_i)
    !ext_reset_n_i && !$past(ext_reset_n_i, 3) |=> !sda_oe_o) else $error("answered in reset");
  // main scenarios reached
  cover property (@(posedge clk_i) $rose(busy_o));
  cover property (@(negedge scl_i) busy_o && !sda_oe_o);
  cover property (@(negedge scl_i) !ext_reset_n_i);
endmodule

bind ees_eeprom_slave ees_eeprom_slave_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .wp_i(wp_i), .ext_reset_i(ext_reset_i),
  .ext_reset_n_i(ext_reset_n_i), .busy_o(busy_o));

// [sim/ees_i2c_master.sv]
`timescale 1ns/1ps
module ees_i2c_master (
  // bus lines, data released means high
  output logic scl_o,
  output logic sda_m_o,
  input wire logic sda_i
);
  // idle bus, clock parked high
  initial begin
    scl_o = 1'b1;
    sda_m_o = 1'b1;
  end
  // one 15 ns clock pulse, line read mid-high
  task automatic bit_x(input logic b, output logic r);
    sda_m_o = b;
    #4 scl_o = 1'b1;
    #4 r = sda_i;
    #4 scl_o = 1'b0;
    #3;
  endtask
  // also used as repeated start
  task automatic start();
    sda_m_o = 1'b1;
    #4 scl_o = 1'b1;
    #4 sda_m_o = 1'b0;
    #4 scl_o = 1'b0;
    #3;
  endtask
  // long idle gap so the core sees the stop
  task automatic stop();
    sda_m_o = 1'b0;
    #4 scl_o = 1'b1;
    #4 sda_m_o = 1'b1;
    #500;
  endtask
  // msb first, then release and sample the ack
  task automatic wr_b(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ak = ~r;
  endtask
  // ack to continue, nack to end
  task automatic rd_b(input logic go, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~go, r);
  endtask
endmodule

// [sim/ees_eeprom_slave_tb.sv]
`timescale 1ns/1ps
module ees_eeprom_slave_tb;
  localparam int WR = 50;
  logic clk_i;
  logic rst_i;
  logic wp_i;
  logic ext_reset_i;
  logic ext_reset_n_i;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe_o;
  logic busy_o;
  wire sda_w;
  int err_total;
  int check_count;
  logic ak;
  logic [7:0] d;
  logic [7:0] exp_q [int];
  // open-drain data wire with pull-up
  assign sda_w = sda_m & ~sda_oe_o;
  ees_eeprom_slave #(.WR_CYCLES(WR)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
    .ext_reset_i(ext_reset_i), .ext_reset_n_i(ext_reset_n_i), .busy_o(busy_o));
  ees_i2c_master u_mst (.scl_o(scl), .sda_m_o(sda_m), .sda_i(sda_w));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one address byte alone, ack kept in ak
  task automatic probe(input logic [7:0] b);
    u_mst.start();
    u_mst.wr_b(b, ak);
    u_mst.stop();
  endtask
  task automatic addr_w(input logic [10:0] a);
    u_mst.start();
    u_mst.wr_b({ees_pkg::DEV_TYPE, a[10:8], 1'b0}, ak);
    chk(8'(ak), 8'h01);
    u_mst.wr_b(a[7:0], ak);
    chk(8'(ak), 8'h01);
  endtask
  // busy, polled unanswered, then answered once done
  task automatic wait_prog();
    int n;
    repeat (8) @(posedge clk_i);
    chk(8'(busy_o), 8'h01);
    probe(8'ha0);
    chk(8'(ak), 8'h00);
    n = 0;
    while (busy_o !== 1'b0 && n < WR + 20) begin
      @(posedge clk_i);
      n++;
    end
    probe(8'ha0);
    chk(8'(ak), 8'h01);
  endtask
  task automatic wr_page(input logic [10:0] a, input int n, input logic [7:0] base);
    logic [10:0] p;
    addr_w(a);
    for (int i = 0; i < n; i++) begin
      u_mst.wr_b(base + 8'(i), ak);
      chk(8'(ak), 8'h01);
      p = {a[10:4], a[3:0] + 4'(i)};
      exp_q[int'(p)] = base + 8'(i);
    end
    u_mst.stop();
    wait_prog();
  endtask
  // dummy write, repeated start, n bytes out
  task automatic rd_seq(input logic [10:0] a, input int n);
    logic [10:0] p;
    addr_w(a);
    u_mst.start();
    u_mst.wr_b({ees_pkg::DEV_TYPE, a[10:8], 1'b1}, ak);
    chk(8'(ak), 8'h01);
    for (int i = 0; i < n; i++) begin
      p = a + 11'(i);
      u_mst.rd_b(i < n - 1, d);
      chk(d, exp_q[int'(p)]);
    end
    u_mst.stop();
    repeat (6) @(posedge clk_i);
    chk(8'(busy_o), 8'h00);
  endtask
  task automatic rd_cur(input logic [10:0] a);
    u_mst.start();
    u_mst.wr_b({ees_pkg::DEV_TYPE, 3'h0, 1'b1}, ak);
    u_mst.rd_b(1'b0, d);
    u_mst.stop();
    chk(d, exp_q[int'(a)]);
  endtask
  // foreign type code, then each reset pin
  task automatic t_refuse();
    probe(8'hb0);
    chk(8'(ak), 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      ext_reset_i <= (k == 0);
      ext_reset_n_i <= (k == 0);
      probe(8'ha0);
      chk(8'(ak), 8'h00);
    end
    @(posedge clk_i);
    ext_reset_i <= 1'b0;
    ext_reset_n_i <= 1'b1;
    probe(8'hff);
    probe(8'ha0);
    chk(8'(ak), 8'h01);
  endtask
  // data byte then repeated start: page dropped, nothing programmed
  task automatic t_abort();
    addr_w(11'h7ff);
    u_mst.wr_b(8'h99, ak);
    chk(8'(ak), 8'h01);
    probe(8'ha0);
    chk(8'(ak), 8'h01);
    repeat (10) @(posedge clk_i);
    chk(8'(busy_o), 8'h00);
    rd_seq(11'h7ff, 1);
  endtask
  // protected: data refused, nothing programmed
  task automatic t_prot();
    @(posedge clk_i);
    wp_i <= 1'b1;
    addr_w(11'h000);
    u_mst.wr_b(8'h5a, ak);
    u_mst.stop();
    chk(8'(ak), 8'h00);
    repeat (10) @(posedge clk_i);
    chk(8'(busy_o), 8'h00);
    wp_i <= 1'b0;
    rd_seq(11'h000, 1);
  endtask
  initial begin
    rst_i = 1'b1;
    wp_i = 1'b0;
    ext_reset_i = 1'b0;
    ext_reset_n_i = 1'b1;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_refuse();
    wr_page(11'h5fe, 17, 8'h40);
    rd_seq(11'h5f0, 1);
    rd_cur(11'h5f1);
    rd_seq(11'h5f2, 14);
    wr_page(11'h7ff, 1, 8'h11);
    wr_page(11'h000, 1, 8'h22);
    rd_seq(11'h7ff, 2);
    rd_seq(11'h7ff, 1);
    rd_cur(11'h000);
    t_abort();
    t_prot();
    test_done();
  end
  // hang guard, far beyond the expected run
  initial begin
    #1_000_000;
    err_total++;
    test_done();
  end
endmodule
